// [adc_analog_model.sv]
// Purpose: Far-side model: analog multiplexer, sample capacitor and comparator.
// Assumes: Comparator answers in the same aclk domain as the sequencer.
// Notes: Each channel has a fixed level, XORed with bias so updates are visible.
`timescale 1ns/1ps

module adc_analog_model (
  input wire logic aclk,
  input wire adc_seq_pkg::analog_out_type analog_out,
  input wire logic [7:0] bias,
  output logic comparator_above
);
  logic [7:0] level;
  logic [7:0] held = 8'h5a;

  always_comb begin
    case (analog_out.channel)
      4'hc: level = 8'hff;
      4'hd: level = 8'h00;
      4'he: level = 8'h80;
      default: level = analog_out.channel[3] ? (8'ha5 ^ {4'h0, analog_out.channel})
                                             : (8'h13 + 8'h1d * {4'h0, analog_out.channel});
    endcase
  end

  // Capacitor follows the input only while the switch is closed, so a late
  // input change reaches the result only through a fresh sample
  always_ff @(posedge aclk) begin
    if (analog_out.sample_switch) begin
      held <= level ^ bias;
    end
  end

  assign comparator_above = (held >= analog_out.trial_code);
endmodule

// [adc_seq_pkg.sv]
// Purpose: Shared constants and carrier types for the converter sequence control.
// Assumes: 25 MHz aclk, AXI4-Lite register access with 32-bit data.
// Notes: All offsets are byte addresses; register data sits in the low byte.
package adc_seq_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_CONTROL_STATUS = 32'h0000_1030;
  localparam logic [31:0] ADDR_RESULT_1 = 32'h0000_1034;
  localparam logic [31:0] ADDR_RESULT_2 = 32'h0000_1038;
  localparam logic [31:0] ADDR_RESULT_3 = 32'h0000_103c;
  localparam logic [31:0] ADDR_RESULT_4 = 32'h0000_1040;
  localparam logic [31:0] ADDR_OPTION = 32'h0000_1044;

  // Field positions
  localparam int FLAG_BIT = 7;
  localparam int ZERO_BIT = 6;
  localparam int POWER_BIT = 7;
  localparam int CLOCK_SOURCE_BIT = 6;

  // Values after reset
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Conversion timing, in converter clock steps
  localparam int CLOCK_HZ = 25_000_000;
  localparam logic [4:0] CONVERSION_CYCLES = 5'h1f + 5'h01 - 5'h01; // last step index
  localparam logic [4:0] SAMPLE_CYCLES = 5'h0c;
  localparam logic [4:0] FIRST_BIT_STEP = 5'h0c;
  localparam logic [4:0] LAST_BIT_STEP = 5'h1b;
  localparam logic [4:0] LAST_STEP = 5'h1f;
  localparam int START_DELAY_CYCLES = 1;
  localparam int FIRST_RESULT_CYCLES = 33;
  // Group resample period: four conversions of 32 steps at 2 MHz
  localparam int RESAMPLE_US = 64;
  localparam int RESAMPLE_REF_HZ = 2_000_000;
  localparam int RESAMPLE_STEPS = RESAMPLE_US * (RESAMPLE_REF_HZ / 1_000_000);

  // Internal RC step rate, about 1.5 MHz, derived from aclk (longest period rounds down)
  localparam int RC_HZ = 1_500_000;
  localparam int RC_DIV_INT = (CLOCK_HZ / RC_HZ < 1) ? 1 : CLOCK_HZ / RC_HZ;
  localparam logic [4:0] RC_DIV_LAST = 5'(RC_DIV_INT - 1);

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_START = 2'b01,
    S_RUN = 2'b10
  } seq_state_type;

  typedef struct packed {
    logic flag;
    logic zero;
    logic continuous_repeat;
    logic group_mode;
    logic [3:0] chan_sel;
  } control_type;

  typedef struct packed {
    logic converter_power_enable;
    logic converter_clock_source;
    logic [5:0] unused;
  } option_type;

  typedef struct packed {
    logic sample_switch;
    logic [3:0] channel;
    logic [7:0] trial_code;
  } analog_out_type;

endpackage

// [adc_sequence_control.sv]
// Purpose: Sequence control of an 8-bit successive approximation converter.
// Assumes: Comparator and low-power hold come from logic on aclk; registers over AXI4-Lite.
// Notes: The RC clock source is modelled as a step strobe divided from aclk.
//
// Notes on behaviour
// - Control bits read/write; flag read-only; bit6 zero
// - Flag sets once four results are filled
// - Any control write clears flag, restarts sequence
// - Write mid-sequence aborts, restarts with new settings
// - Continuous mode keeps converting; flag stays set
// - One-shot fills four results then halts
// - Single mode converts selected channel four times
// - Group mode: high select bits pick group
// - Channel select decodes inputs, references, reserved
// - Group channel low bits map to results 1-4
// - Results are 8-bit, read-only, writes ignored
// - First result valid 33 cycles after write
// - Option bit 7 enables converter power
// - Option bit 6 selects E or RC clock
// - Clock source bit enables charge pump oscillator
// - E clock mode samples comparator synchronously
// - Continuous group resamples each channel every 128 steps (5.12 us on 25 MHz E clock)
// - Each conversion takes 32 clock cycles
// - Sequence begins one cycle after the write
// - Sample switch closed only first 12 cycles
// - Low-power hold suspends, then resamples channel
`timescale 1ns/1ps

module adc_sequence_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_above,
  input wire logic low_power_hold,
  output adc_seq_pkg::analog_out_type analog_out,
  output logic converter_powered,
  output logic rc_oscillator_enable,
  output logic charge_pump_oscillator_enable,
  output logic channel_reserved
);

  // Register state
  adc_seq_pkg::control_type control;
  adc_seq_pkg::option_type option;
  logic [7:0] result [4];

  // Bus holding registers
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Sequencer state
  adc_seq_pkg::seq_state_type state;
  logic [4:0] step;
  logic [1:0] slot;
  logic [7:0] sar;
  logic [7:0] mask;
  logic [4:0] rc_div;

  // Bus decode
  wire write_fire = aw_held && w_held && !s_axi_bvalid;
  wire hit_control_w = aw_addr == adc_seq_pkg::ADDR_CONTROL_STATUS;
  wire hit_option_w = aw_addr == adc_seq_pkg::ADDR_OPTION;
  wire hit_result_w = aw_addr == adc_seq_pkg::ADDR_RESULT_1 ||
    aw_addr == adc_seq_pkg::ADDR_RESULT_2 || aw_addr == adc_seq_pkg::ADDR_RESULT_3 ||
    aw_addr == adc_seq_pkg::ADDR_RESULT_4;
  wire write_mapped = hit_control_w || hit_option_w || hit_result_w;
  wire control_write = write_fire && hit_control_w;
  wire option_write = write_fire && hit_option_w && w_strb[0];
  wire read_fire = s_axi_arvalid && s_axi_arready;

  // Read data selection
  wire [7:0] control_read = {control.flag, 1'b0, control[5:0]};
  wire [7:0] option_read = {option.converter_power_enable, option.converter_clock_source,
    6'h00};
  wire rd_control = s_axi_araddr == adc_seq_pkg::ADDR_CONTROL_STATUS;
  wire rd_option = s_axi_araddr == adc_seq_pkg::ADDR_OPTION;
  wire rd_r1 = s_axi_araddr == adc_seq_pkg::ADDR_RESULT_1;
  wire rd_r2 = s_axi_araddr == adc_seq_pkg::ADDR_RESULT_2;
  wire rd_r3 = s_axi_araddr == adc_seq_pkg::ADDR_RESULT_3;
  wire rd_r4 = s_axi_araddr == adc_seq_pkg::ADDR_RESULT_4;
  wire read_mapped = rd_control || rd_option || rd_r1 || rd_r2 || rd_r3 || rd_r4;
  wire [7:0] read_byte = rd_control ? control_read :
    rd_option ? option_read :
    rd_r1 ? result[0] :
    rd_r2 ? result[1] :
    rd_r3 ? result[2] :
    rd_r4 ? result[3] : 8'h00;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // Sequencer decode
  wire powered = option.converter_power_enable;
  wire hold = low_power_hold || !powered;
  // E clock mode steps every aclk edge; RC mode steps on a divided strobe
  wire step_tick = option.converter_clock_source ? (rc_div == adc_seq_pkg::RC_DIV_LAST) :
    1'b1;
  wire running = state == adc_seq_pkg::S_RUN;
  wire decide = running && !hold && step_tick && step >= adc_seq_pkg::FIRST_BIT_STEP &&
    step <= adc_seq_pkg::LAST_BIT_STEP && step[0];
  wire store_fire = running && !hold && step_tick && step == adc_seq_pkg::LAST_STEP;
  wire last_slot = slot == 2'h3;
  // Successive approximation: keep or drop trial bit, then offer the next one
  wire [7:0] next_sar = (comparator_above ? sar : (sar & ~mask)) | (mask >> 1);
  // Group mode ignores the low select bits and walks the group in slot order
  wire [3:0] channel = control.group_mode ? {control.chan_sel[3:2], slot} :
    control.chan_sel;
  // Codes 1000-1011 and 1111 select nothing; the flag lets the mux park
  wire reserved_code = (channel[3:2] == 2'b10) || (channel == 4'hf);

  assign analog_out.sample_switch = running && !hold &&
    step < adc_seq_pkg::SAMPLE_CYCLES;
  assign analog_out.channel = channel;
  assign analog_out.trial_code = sar;
  assign converter_powered = powered;
  assign rc_oscillator_enable = option.converter_clock_source;
  assign charge_pump_oscillator_enable = option.converter_clock_source;
  assign channel_reserved = reserved_code;

  // AXI write address and data are captured independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (write_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (write_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; writes to result addresses answer OKAY and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= adc_seq_pkg::RESP_OKAY;
    end else if (write_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= write_mapped ? adc_seq_pkg::RESP_OKAY : adc_seq_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= adc_seq_pkg::RESP_OKAY;
    end else if (read_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, read_byte};
      s_axi_rresp <= read_mapped ? adc_seq_pkg::RESP_OKAY : adc_seq_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Option register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option <= adc_seq_pkg::OPTION_RESET;
    end else if (option_write) begin
      option <= {w_data[adc_seq_pkg::POWER_BIT], w_data[adc_seq_pkg::CLOCK_SOURCE_BIT], 6'h00};
    end
  end

  // Control register; the flag is cleared by a write even if a sequence ends in that cycle,
  // because the write also aborts the sequence that would have set it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control <= adc_seq_pkg::CONTROL_RESET;
    end else if (control_write) begin
      control.flag <= 1'b0;
      if (w_strb[0]) begin
        control[5:0] <= w_data[5:0];
      end
    end else if (store_fire && last_slot) begin
      control.flag <= 1'b1;
    end
  end

  // RC step divider, free running so the step rate is steady
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_div <= 5'h00;
    end else if (rc_div == adc_seq_pkg::RC_DIV_LAST) begin
      rc_div <= 5'h00;
    end else begin
      rc_div <= rc_div + 5'h01;
    end
  end

  // Sequencer: write -> START for one cycle -> RUN, 32 steps per conversion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= adc_seq_pkg::S_IDLE;
      step <= 5'h00;
      slot <= 2'h0;
      sar <= 8'h00;
      mask <= 8'h00;
    end else if (control_write) begin
      state <= adc_seq_pkg::S_START;
      step <= 5'h00;
      slot <= 2'h0;
    end else begin
      case (state)
        adc_seq_pkg::S_IDLE: begin
          step <= 5'h00;
        end
        adc_seq_pkg::S_START: begin
          if (!hold) begin
            state <= adc_seq_pkg::S_RUN;
            step <= 5'h00;
          end
        end
        adc_seq_pkg::S_RUN: begin
          if (hold) begin
            // Restart the current channel from its sample window on resume
            step <= 5'h00;
          end else if (step_tick) begin
            step <= step + 5'h01;
            if (step == adc_seq_pkg::FIRST_BIT_STEP - 5'h01) begin
              sar <= 8'h80;
              mask <= 8'h80;
            end
            if (decide) begin
              sar <= next_sar;
              mask <= mask >> 1;
            end
            if (store_fire) begin
              step <= 5'h00;
              slot <= slot + 2'h1;
              if (last_slot && !control.continuous_repeat) begin
                state <= adc_seq_pkg::S_IDLE;
              end
            end
          end
        end
        default: begin
          state <= adc_seq_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Result registers: only the sequencer writes them, the bus never does
  generate
    for (genvar i = 0; i < 4; i++) begin : g_result
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          result[i] <= 8'h00;
        end else if (store_fire && slot == 2'(i)) begin
          result[i] <= sar;
        end
      end
    end
  endgenerate

  // Helper: cycles since the last control write, and whether the run was undisturbed
  logic [6:0] since_write;
  logic clean_run;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_write <= 7'h7f;
      clean_run <= 1'b0;
    end else if (control_write) begin
      since_write <= 7'h00;
      clean_run <= !hold && !option.converter_clock_source;
    end else begin
      if (since_write != 7'h7f) begin
        since_write <= since_write + 7'h01;
      end
      if (hold || option.converter_clock_source) begin
        clean_run <= 1'b0;
      end
    end
  end

  sequence s_write_taken;
    control_write;
  endsequence

  sequence s_restarted;
    !control.flag && state == adc_seq_pkg::S_START && slot == 2'h0;
  endsequence

  property p_bit6_zero;
    @(posedge aclk) disable iff (!aresetn)
      read_fire && rd_control |=> s_axi_rdata[adc_seq_pkg::ZERO_BIT] == 1'b0;
  endproperty
  a_bit6_zero: assert property (p_bit6_zero) else $error("bit 6 read as one");

  property p_flag_sets;
    @(posedge aclk) disable iff (!aresetn)
      store_fire && last_slot && !control_write |=> control.flag && slot == 2'h0;
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("flag not set after slot 4");

  property p_write_restarts;
    @(posedge aclk) disable iff (!aresetn)
      s_write_taken |=> s_restarted;
  endproperty
  a_write_restarts: assert property (p_write_restarts) else $error("write did not restart");

  property p_first_result;
    @(posedge aclk) disable iff (!aresetn)
      store_fire && slot == 2'h0 && clean_run && since_write < 7'h30 |->
      since_write == 7'(adc_seq_pkg::FIRST_RESULT_CYCLES - 1);
  endproperty
  a_first_result: assert property (p_first_result) else $error("first result late or early");

  // Counted from the write, not from the step counter, so a wrong step count shows up
  property p_sample_window;
    @(posedge aclk) disable iff (!aresetn)
      clean_run && !hold && since_write != 7'h00 && since_write <= 7'h20 |->
      analog_out.sample_switch == (since_write <= 7'(adc_seq_pkg::SAMPLE_CYCLES));
  endproperty
  a_sample_window: assert property (p_sample_window) else $error("switch closed outside sample");

  property p_one_shot_halts;
    @(posedge aclk) disable iff (!aresetn)
      store_fire && last_slot && !control.continuous_repeat && !control_write
      |=> state == adc_seq_pkg::S_IDLE ##1 state == adc_seq_pkg::S_IDLE || $past(control_write);
  endproperty
  a_one_shot_halts: assert property (p_one_shot_halts) else $error("one-shot did not halt");

  property p_flag_stays;
    @(posedge aclk) disable iff (!aresetn)
      control.flag && !control_write |=> control.flag;
  endproperty
  a_flag_stays: assert property (p_flag_stays) else $error("flag dropped without a write");

  property p_group_channel;
    @(posedge aclk) disable iff (!aresetn)
      running && control.group_mode |-> analog_out.channel[3:2] == control.chan_sel[3:2] &&
      analog_out.channel[1:0] == slot;
  endproperty
  a_group_channel: assert property (p_group_channel) else $error("wrong group channel");

  property p_single_channel;
    @(posedge aclk) disable iff (!aresetn)
      running && !control.group_mode |-> analog_out.channel == control.chan_sel;
  endproperty
  a_single_channel: assert property (p_single_channel) else $error("wrong single channel");

  property p_hold_resamples;
    @(posedge aclk) disable iff (!aresetn)
      running && hold && !control_write |=> step == 5'h00 && !analog_out.sample_switch || !hold;
  endproperty
  a_hold_resamples: assert property (p_hold_resamples) else $error("hold did not rewind");

  property p_results_stable;
    @(posedge aclk) disable iff (!aresetn)
      !store_fire |=> $stable(result[0]) && $stable(result[1]) && $stable(result[2]) &&
      $stable(result[3]);
  endproperty
  a_results_stable: assert property (p_results_stable) else $error("result changed");

endmodule

// [adc_sequence_control_tb.sv]
// Purpose: Self-checking bench for the converter sequence control.
// Assumes: AXI4-Lite master tasks; analog far side from adc_analog_model.
// Notes: Power-up settle wait is kept; the RC start wait is scaled down to fit the run.
`timescale 1ns/1ps

module adc_sequence_control_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic low_power_hold = 1'b0;
  logic [7:0] bias = 8'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic comparator_above, converter_powered, rc_oscillator_enable;
  logic charge_pump_oscillator_enable, channel_reserved;
  adc_seq_pkg::analog_out_type analog_out;
  int n_mismatch = 0;
  int n_checks = 0;
  localparam logic [31:0] CTRL = adc_seq_pkg::ADDR_CONTROL_STATUS;
  localparam logic [31:0] OPT = adc_seq_pkg::ADDR_OPTION;
  localparam logic [31:0] RES [4] = '{adc_seq_pkg::ADDR_RESULT_1, adc_seq_pkg::ADDR_RESULT_2,
                                      adc_seq_pkg::ADDR_RESULT_3, adc_seq_pkg::ADDR_RESULT_4};
  localparam logic [1:0] OK = adc_seq_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = adc_seq_pkg::RESP_SLVERR;

  adc_sequence_control adc_sequence_control_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .comparator_above(comparator_above), .low_power_hold(low_power_hold),
    .analog_out(analog_out), .converter_powered(converter_powered),
    .rc_oscillator_enable(rc_oscillator_enable),
    .charge_pump_oscillator_enable(charge_pump_oscillator_enable),
    .channel_reserved(channel_reserved)
  );

  adc_analog_model adc_analog_model_i (
    .aclk(aclk), .analog_out(analog_out), .bias(bias), .comparator_above(comparator_above)
  );

  always #20 aclk = ~aclk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic bail();
    n_mismatch++;
    $display("unexpected at %0t: wait ran out", $time);
    conclude();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic await(ref logic sig);
    for (int n = 0; n < 2000; n++) begin
      @(negedge aclk);
      if (sig === 1'b1) return;
    end
    bail();
  endtask

  // Returns just after the edge that takes the write response
  task automatic wr(input logic [31:0] addr, input logic [7:0] val, input logic [1:0] resp);
    logic aw_go, w_go;
    @(posedge aclk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= {24'h0, val};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_go = s_axi_awvalid && s_axi_awready;
      w_go = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (aw_go) s_axi_awvalid <= 1'b0;
      if (w_go) s_axi_wvalid <= 1'b0;
    end while (!((aw_go || !s_axi_awvalid) && (w_go || !s_axi_wvalid)));
    await(s_axi_bvalid);
    chk(s_axi_bresp, resp, "bresp");
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] addr, output logic [31:0] data, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    await(s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    await(s_axi_rvalid);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdc(input logic [31:0] addr, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(addr, d, r);
    chk(d, {24'h0, exp}, "read data");
    chk(r, OK, "rresp");
  endtask

  function automatic logic [7:0] lvl(input logic [3:0] ch, input logic [7:0] b);
    logic [7:0] v;
    case (ch)
      4'hc: v = 8'hff;
      4'hd: v = 8'h00;
      4'he: v = 8'h80;
      default: v = ch[3] ? (8'ha5 ^ {4'h0, ch}) : (8'h13 + 8'h1d * {4'h0, ch});
    endcase
    return v ^ b;
  endfunction

  task automatic res_chk(input logic [3:0] ch, input logic grp, input logic [7:0] b);
    for (int k = 0; k < 4; k++) begin
      rdc(RES[k], lvl(grp ? {ch[3:2], 2'(k)} : ch, b));
    end
  endtask

  task automatic wait_done(input logic [7:0] ctl);
    logic [31:0] d;
    logic [1:0] r;
    for (int n = 0; n < 1500; n++) begin
      rd(CTRL, d, r);
      if (d[7] === 1'b1) break;
    end
    if (d[7] !== 1'b1) bail();
    chk(d, {24'h0, 2'b10, ctl[5:0]}, "control when done");
  endtask

  // Reads result 1 with the address taken nwait+2 edges after the edge that takes the control write
  task automatic start_read(input logic [7:0] ctl, input int nwait, input logic [7:0] exp);
    wr(CTRL, ctl, OK);
    for (int i = 0; i < nwait; i++) begin
      @(negedge aclk);
      chk(analog_out.sample_switch, i < 12, "sample switch");
      chk(analog_out.channel, ctl[3:0], "mux channel");
    end
    rdc(RES[0], exp);
  endtask

  initial begin
    repeat (100000) @(posedge aclk);
    bail();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] ctl;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(CTRL, adc_seq_pkg::CONTROL_RESET);
    rdc(OPT, adc_seq_pkg::OPTION_RESET);
    res_chk(4'hd, 1'b0, 8'h00);
    wr(OPT, 8'h80, OK);
    repeat (2500) @(posedge aclk);
    rdc(OPT, 8'h80);
    chk(converter_powered, 1'b1, "power enable");
    chk(rc_oscillator_enable, 1'b0, "rc off");
    wr(CTRL, 8'hff, OK);
    rdc(CTRL, 8'h3f);
    for (int ch = 0; ch < 16; ch++) begin
      ctl = 8'(ch);
      wr(CTRL, ctl, OK);
      chk(channel_reserved, ch inside {[8:11], 15}, "reserved decode");
      chk(analog_out.channel, ctl[3:0], "mux channel");
      wait_done(ctl);
      res_chk(ctl[3:0], 1'b0, 8'h00);
    end
    start_read(8'h03, 31, lvl(4'hf, 8'h00));
    start_read(8'h01, 32, lvl(4'h1, 8'h00));
    wait_done(8'h01);
    res_chk(4'h1, 1'b0, 8'h00);
    foreach (RES[k]) begin
      ctl = 8'h10 | 8'(k * 5 + 2);
      wr(CTRL, ctl, OK);
      wait_done(ctl);
      res_chk(ctl[3:0], 1'b1, 8'h00);
    end
    wr(RES[0], 8'hff, OK);
    rdc(RES[0], lvl(4'h0, 8'h00));
    wr(32'h0000_1048, 8'h11, ERR);
    rd(32'h0000_1048, d, r);
    chk(d, 32'h0, "unmapped data");
    chk(r, ERR, "unmapped resp");
    wr(CTRL, 8'h06, OK);
    repeat (20) @(posedge aclk);
    low_power_hold <= 1'b1;
    bias <= 8'h3c;
    repeat (10) @(posedge aclk);
    low_power_hold <= 1'b0;
    wait_done(8'h06);
    res_chk(4'h6, 1'b0, 8'h3c);
    bias <= 8'h00;
    repeat (300) @(posedge aclk);
    chk(analog_out.sample_switch, 1'b0, "idle switch");
    res_chk(4'h6, 1'b0, 8'h3c);
    foreach (RES[k]) begin
      if (k < 2) begin
        ctl = (k == 0) ? 8'h22 : 8'h35;
        bias <= 8'h00;
        wr(CTRL, ctl, OK);
        wait_done(ctl);
        res_chk(ctl[3:0], ctl[4], 8'h00);
        bias <= 8'h5a;
        repeat (300) @(posedge aclk);
        res_chk(ctl[3:0], ctl[4], 8'h5a);
        rdc(CTRL, {2'b10, ctl[5:0]});
      end
    end
    bias <= 8'h00;
    wr(OPT, 8'hc0, OK);
    chk(rc_oscillator_enable, 1'b1, "rc on");
    chk(charge_pump_oscillator_enable, 1'b1, "pump oscillator");
    repeat (2500) @(posedge aclk);
    wr(CTRL, 8'h01, OK);
    repeat (200) @(posedge aclk);
    rdc(CTRL, 8'h01);
    wait_done(8'h01);
    res_chk(4'h1, 1'b0, 8'h00);
    conclude();
  end
endmodule
